// ---- src/citc_pkg.sv ----
/*
 package of the instruction timing core: encodings, layouts, reset values.
 assumes one system clock; program memory answers one clock after its address.
*/
package citc_pkg;
	// one instruction cycle in system clocks
	localparam int PHASES = 4;
	localparam int PC_W = 11;
	localparam int DM_AW = 7;
	localparam int DM_WORDS = 80;
	localparam int STACK_DEPTH = 4;
	localparam int IW = 15;
	// data address that aliases the low program counter byte
	localparam logic [6:0] PCL_IDX = 7'h02;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [14:0] IR_RST = 15'h0000;
	localparam logic [1:0] DBNC_MAX = 2'h2;
	// opcodes in word bits 14:11
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_JMP = 4'h1;
	localparam logic [3:0] OP_CALL = 4'h2;
	localparam logic [3:0] OP_RET = 4'h3;
	localparam logic [3:0] OP_ALU = 4'h4;
	localparam logic [3:0] OP_ROT = 4'h5;
	localparam logic [3:0] OP_MOVA = 4'h6;
	localparam logic [3:0] OP_LDA = 4'h7;
	localparam logic [3:0] OP_SZ = 4'h8;
	localparam logic [3:0] OP_SBZ = 4'h9;
	localparam logic [3:0] OP_TAB = 4'hA;
	localparam logic [3:0] OP_MOVI = 4'hB;
	// alu sub codes
	localparam logic [2:0] ALU_ADD = 3'h0;
	localparam logic [2:0] ALU_SUB = 3'h1;
	localparam logic [2:0] ALU_AND = 3'h2;
	localparam logic [2:0] ALU_OR = 3'h3;
	localparam logic [2:0] ALU_XOR = 3'h4;
	localparam logic [2:0] ALU_CPL = 3'h5;
	localparam logic [2:0] ALU_INC = 3'h6;
	localparam logic [2:0] ALU_DEC = 3'h7;
	// rotate sub codes
	localparam logic [2:0] ROT_R = 3'h0;
	localparam logic [2:0] ROT_L = 3'h1;
	localparam logic [2:0] ROT_RC = 3'h2;
	localparam logic [2:0] ROT_LC = 3'h3;
	// instruction word layout
	typedef struct packed {
		logic [3:0] op;
		logic       toMem;
		logic [2:0] sub;
		logic [6:0] addr;
	} citc_instr_t;
	// options fixed at programming
	typedef struct packed {
		logic       wdtEn;
		logic       wdtOwnOsc;
		logic [7:0] wakeEn;
		logic       simEn;
		logic       softCsEn;
		logic       wcolEn;
		logic       twoWireOpt;
		logic [1:0] dbnc;
	} citc_cfg_t;
	typedef enum logic [1:0] {PH0, PH1, PH2, PH3} citc_phase_t;
endpackage

// ---- src/citc_core.sv ----
/*
 instruction timing and flow control core with fixed configuration options.
 assumes a synchronous program memory: data valid one clock after progAddr.
*/
`timescale 1ns/1ps
module citc_core #(
	parameter int DM_WORDS = citc_pkg::DM_WORDS
) (
	input  wire logic                clock,
	input  wire logic                sys_rst,
	input  wire logic                ce,
	input  wire logic [14:0]         progData,
	input  wire citc_pkg::citc_cfg_t cfgIn,
	input  wire logic                wdtOscPin,
	input  wire logic [7:0]          wakePortPins,
	output logic [10:0]              progAddr,
	output logic [7:0]               accOut,
	output logic                     zeroFlag,
	output logic                     carryFlag,
	output logic                     instrTick,
	output logic                     watchdogTick,
	output logic                     wakeReq,
	output citc_pkg::citc_cfg_t      cfgOut
);
	// a data address holds seven bits; fewer than eight words leaves no room to work
	if (DM_WORDS < 8 || DM_WORDS > 128)
	begin : g_words_check
		$error("DM_WORDS out of range");
	end

	citc_pkg::citc_phase_t phaseReg, phaseNext;  // position in cycle
	logic [10:0] pcReg, pcNext;                  // word being fetched
	logic [10:0] retReg, retNext;                // pc held during table read
	logic [14:0] irReg, irNext;                  // word being executed
	logic        irValid, irValidNext;           // cleared on discard
	logic        tblPend, tblPendNext;           // table read second cycle
	logic [10:0] stackReg [citc_pkg::STACK_DEPTH];
	logic [10:0] stackNext [citc_pkg::STACK_DEPTH];
	logic [1:0]  spReg, spNext;                  // next free slot
	logic [10:0] progAddrNext;
	logic [7:0]  accNext;
	logic        zeroNext, carryNext, tickNext, wdtNext, wakeNext;
	logic [7:0]  dmem [DM_WORDS];                // data memory
	logic        memWe;
	logic [7:0]  memWd, rdVal;
	logic [8:0]  sum9;                           // nine-bit add/sub
	logic        execNow;
	logic        wdtS1, wdtS2, wdtS3;            // oscillator synchroniser
	logic [7:0]  portS1, portS2;                 // pin synchroniser
	citc_pkg::citc_cfg_t cfgNext;
	citc_pkg::citc_instr_t ir;

	// read port, low pc byte aliased into data space
	function automatic logic [7:0] rdMem(input logic [6:0] a, input logic [10:0] pc);
		logic [10:0] cur;
		cur = pc - 11'h001;
		if (a == citc_pkg::PCL_IDX)
			rdMem = cur[7:0];
		else if (32'(a) < DM_WORDS)
			rdMem = dmem[a];
		else
			rdMem = 8'h00;
	endfunction

	assign ir = citc_pkg::citc_instr_t'(irReg);
	assign execNow = (phaseReg == citc_pkg::PH3) && irValid;
	assign rdVal = rdMem(ir.addr, pcReg);

	// options are captured only while reset is held
	always_comb
	begin
		cfgNext = cfgIn;
		if (cfgIn.dbnc > citc_pkg::DBNC_MAX)
			cfgNext.dbnc = citc_pkg::DBNC_MAX;
	end

	// side outputs: tick, watchdog clock, wake
	always_comb
	begin
		tickNext = (phaseReg == citc_pkg::PH3);
		// internal oscillator edge or instruction clock, gated by enable
		wdtNext = cfgOut.wdtEn &
			(cfgOut.wdtOwnOsc ? (wdtS2 & ~wdtS3) : tickNext);
		wakeNext = |(cfgOut.wakeEn & portS2);
	end

	// sequencing and datapath
	always_comb
	begin
		phaseNext = phaseReg;
		pcNext = pcReg;
		retNext = retReg;
		irNext = irReg;
		irValidNext = irValid;
		tblPendNext = tblPend;
		stackNext = stackReg;
		spNext = spReg;
		progAddrNext = progAddr;
		accNext = accOut;
		zeroNext = zeroFlag;
		carryNext = carryFlag;
		memWe = 1'b0;
		memWd = 8'h00;
		sum9 = 9'h000;
		unique case (phaseReg)
			citc_pkg::PH0: phaseNext = citc_pkg::PH1;
			citc_pkg::PH1: phaseNext = citc_pkg::PH2;
			citc_pkg::PH2: phaseNext = citc_pkg::PH3;
			citc_pkg::PH3: phaseNext = citc_pkg::PH0;
		endcase
		// table word arrived; put the sequential fetch back
		if (phaseReg == citc_pkg::PH1 && tblPend)
		begin
			accNext = progData[7:0];
			progAddrNext = retReg;
			tblPendNext = 1'b0;
		end
		if (phaseReg == citc_pkg::PH3)
		begin
			irNext = progData;
			irValidNext = 1'b1;
			pcNext = pcReg + 11'h001;
			if (irValid)
			begin
				unique case (ir.op)
					citc_pkg::OP_JMP:
					begin
						pcNext = irReg[10:0];
						irValidNext = 1'b0;
					end
					citc_pkg::OP_CALL:
					begin
						stackNext[spReg] = pcReg;
						spNext = spReg + 2'h1;
						pcNext = irReg[10:0];
						irValidNext = 1'b0;
					end
					citc_pkg::OP_RET:
					begin
						spNext = spReg - 2'h1;
						pcNext = stackReg[spNext];
						irValidNext = 1'b0;
					end
					citc_pkg::OP_ALU:
					begin
						unique case (ir.sub)
							citc_pkg::ALU_ADD: sum9 = {1'b0, accOut} + {1'b0, rdVal};
							citc_pkg::ALU_SUB: sum9 = {1'b0, accOut} - {1'b0, rdVal};
							citc_pkg::ALU_AND: sum9 = {1'b0, accOut & rdVal};
							citc_pkg::ALU_OR:  sum9 = {1'b0, accOut | rdVal};
							citc_pkg::ALU_XOR: sum9 = {1'b0, accOut ^ rdVal};
							citc_pkg::ALU_CPL: sum9 = {1'b0, ~rdVal};
							citc_pkg::ALU_INC: sum9 = {1'b0, rdVal + 8'h01};
							citc_pkg::ALU_DEC: sum9 = {1'b0, rdVal - 8'h01};
						endcase
						zeroNext = (sum9[7:0] == 8'h00);
						// bit 8 is carry on add, borrow on subtract
						if (ir.sub == citc_pkg::ALU_ADD || ir.sub == citc_pkg::ALU_SUB)
							carryNext = sum9[8];
						memWd = sum9[7:0];
					end
					citc_pkg::OP_ROT:
					begin
						unique case (ir.sub[1:0])
							2'h0: memWd = {rdVal[0], rdVal[7:1]};
							2'h1: memWd = {rdVal[6:0], rdVal[7]};
							2'h2: memWd = {carryFlag, rdVal[7:1]};
							2'h3: memWd = {rdVal[6:0], carryFlag};
						endcase
						if (ir.sub[1])
							carryNext = ir.sub[0] ? rdVal[7] : rdVal[0];
					end
					citc_pkg::OP_MOVA: memWd = accOut;
					citc_pkg::OP_LDA: accNext = rdVal;
					citc_pkg::OP_SZ:
						if (rdVal == 8'h00)
							irValidNext = 1'b0;
					citc_pkg::OP_SBZ:
						if (!rdVal[ir.sub])
							irValidNext = 1'b0;
					citc_pkg::OP_TAB:
					begin
						// second cycle fetches the table word, then resumes;
						// the prefetched word is dropped and fetched again, so it runs once
						retNext = pcReg;
						pcNext = pcReg;
						irValidNext = 1'b0;
						tblPendNext = 1'b1;
					end
					citc_pkg::OP_MOVI: accNext = irReg[7:0];
					default: ;  // no operation and spare codes
				endcase
				// result routing for ops with a destination
				if (ir.op == citc_pkg::OP_ALU || ir.op == citc_pkg::OP_ROT || ir.op == citc_pkg::OP_MOVA)
				begin
					if (!ir.toMem && ir.op != citc_pkg::OP_MOVA)
						accNext = memWd;
					else if (ir.addr == citc_pkg::PCL_IDX)
					begin
						pcNext = {pcReg[10:8], memWd};
						irValidNext = 1'b0;
					end
					else
						memWe = 1'b1;
				end
			end
			progAddrNext = tblPendNext ? {pcReg[10:8], accNext} : pcNext;
		end
	end

	// state registers; sys_rst still resets them, everything else holds while ce is low
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			phaseReg <= citc_pkg::PH0;
			pcReg <= citc_pkg::PC_RST;
			retReg <= citc_pkg::PC_RST;
			irReg <= citc_pkg::IR_RST;
			irValid <= 1'b0;
			tblPend <= 1'b0;
			spReg <= 2'h0;
			stackReg <= '{default: citc_pkg::PC_RST};
			progAddr <= citc_pkg::PC_RST;
			accOut <= citc_pkg::ACC_RST;
			zeroFlag <= 1'b0;
			carryFlag <= 1'b0;
			instrTick <= 1'b0;
			watchdogTick <= 1'b0;
			wakeReq <= 1'b0;
			wdtS1 <= 1'b0;
			wdtS2 <= 1'b0;
			wdtS3 <= 1'b0;
			portS1 <= 8'h00;
			portS2 <= 8'h00;
			cfgOut <= cfgNext;
		end
		else if (ce)
		begin
			phaseReg <= phaseNext;
			pcReg <= pcNext;
			retReg <= retNext;
			irReg <= irNext;
			irValid <= irValidNext;
			tblPend <= tblPendNext;
			spReg <= spNext;
			stackReg <= stackNext;
			progAddr <= progAddrNext;
			accOut <= accNext;
			zeroFlag <= zeroNext;
			carryFlag <= carryNext;
			instrTick <= tickNext;
			watchdogTick <= wdtNext;
			wakeReq <= wakeNext;
			wdtS1 <= wdtOscPin;
			wdtS2 <= wdtS1;
			wdtS3 <= wdtS2;
			portS1 <= wakePortPins;
			portS2 <= portS1;
		end
	end

	// data memory write port; contents are not reset
	always_ff @(posedge clock)
	begin
		if (ce && !sys_rst && memWe && 32'(ir.addr) < DM_WORDS)
			dmem[ir.addr] <= memWd;
	end

	// checks
	a_phase_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		ce && phaseReg == citc_pkg::PH3 |=> phaseReg == citc_pkg::PH0 && instrTick)
		else $error("cycle did not wrap after four clocks");
	a_jump_flush: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_JMP |=> !irValid && pcReg == $past(irReg[10:0]))
		else $error("jump did not flush and redirect");
	a_pcl_write: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_MOVA && ir.addr == citc_pkg::PCL_IDX
		|=> !irValid && pcReg[7:0] == $past(accOut))
		else $error("low pc write did not jump");
	a_skip_taken: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_SZ |=> irValid == ($past(rdVal) != 8'h00))
		else $error("skip cost wrong");
	a_logic_zero: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_ALU && ir.sub == citc_pkg::ALU_AND
		|=> zeroFlag == ($past(accOut & rdVal) == 8'h00))
		else $error("zero flag wrong after and");
	a_inc_acc: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_ALU && ir.sub == citc_pkg::ALU_INC && !ir.toMem
		|=> accOut == 8'($past(rdVal) + 8'h01))
		else $error("increment to acc wrong");
	a_call_push: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_CALL |=> stackReg[$past(spReg)] == $past(pcReg))
		else $error("call did not save return address");
	a_add_carry: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_ALU && ir.sub == citc_pkg::ALU_ADD
		|=> carryFlag == (({1'b0, $past(accOut)} + {1'b0, $past(rdVal)}) > 9'h0FF))
		else $error("add carry wrong");
	a_rrc_carry: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_ROT && ir.sub == citc_pkg::ROT_RC
		|=> carryFlag == $past(rdVal[0]))
		else $error("rotate through carry wrong");
	a_cfg_fixed: assert property (@(posedge clock) disable iff (sys_rst)
		##1 $stable(cfgOut) && cfgOut.dbnc <= citc_pkg::DBNC_MAX)
		else $error("options changed after reset");
	a_wdt_off: assert property (@(posedge clock) disable iff (sys_rst)
		!cfgOut.wdtEn |=> !watchdogTick)
		else $error("watchdog ticks while disabled");
	a_tab_two: assert property (@(posedge clock) disable iff (sys_rst)
		ce && execNow && ir.op == citc_pkg::OP_TAB |=> tblPend && !irValid)
		else $error("table read timing wrong");
	c_call: cover property (@(posedge clock) ce && execNow && ir.op == citc_pkg::OP_CALL);
	c_ret: cover property (@(posedge clock) ce && execNow && ir.op == citc_pkg::OP_RET);
	c_skip: cover property (@(posedge clock) ce && execNow && ir.op == citc_pkg::OP_SBZ && !irValidNext);
endmodule

// ---- test/citc_prog_mem.sv ----
/*
 program memory model: 2K words of 15 bits, synchronous read.
 assumes the bench fills mem by hierarchical writes before reset is released.
*/
`timescale 1ns/1ps
module citc_prog_mem (
	input  wire logic        clock,
	input  wire logic [10:0] progAddr,
	output logic [14:0]      progData
);
	logic [14:0] mem [0:2047]; // program words, loaded by the bench

	// word answers one clock after its address, the slowest the core allows
	always_ff @(posedge clock)
	begin
		progData <= mem[progAddr];
	end
endmodule

// ---- test/tb_cpu_instruction_timing_control.sv ----
/*
 self-checking bench of the instruction timing core: alu, rotate, flow, options.
 assumes citc_core, citc_pkg and the program memory model are compiled first.
*/
`timescale 1ns/1ps
module tb_cpu_instruction_timing_control;
	logic                clock;        // system clock
	logic                sys_rst;      // sync reset
	logic [14:0]         progData;     // memory word
	citc_pkg::citc_cfg_t cfgIn;        // options offered
	logic                wdtOscPin;    // slow watchdog osc
	logic [7:0]          wakePortPins; // wake pins
	logic [10:0]         progAddr;     // fetch address
	logic [7:0]          accOut;       // accumulator
	logic                zeroFlag;     // zero flag
	logic                carryFlag;    // carry or borrow
	logic                instrTick;    // one per cycle
	logic                watchdogTick; // watchdog clock pulse
	logic                wakeReq;      // wake level
	citc_pkg::citc_cfg_t cfgOut;       // options held
	int                  errTotal;     // mismatches
	int                  checks;       // comparisons
	int                  tkCnt;        // instruction ticks in window
	int                  wdCnt;        // watchdog ticks in window
	int                  seed = 32'hBB31F2CE;
	logic [10:0]         trace [$];    // fetch addresses seen at each tick
	logic [10:0]         expTr [16] = '{11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h020, 11'h021, 11'h022,
		11'h023, 11'h005, 11'h006, 11'h007, 11'h008, 11'h030, 11'h031, 11'h032};

	// ce tied high: stalls would blur the exact tick counts
	citc_core DUT (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .progData(progData), .cfgIn(cfgIn),
		.wdtOscPin(wdtOscPin), .wakePortPins(wakePortPins), .progAddr(progAddr), .accOut(accOut),
		.zeroFlag(zeroFlag), .carryFlag(carryFlag), .instrTick(instrTick), .watchdogTick(watchdogTick),
		.wakeReq(wakeReq), .cfgOut(cfgOut));
	citc_prog_mem pm (.clock(clock), .progAddr(progAddr), .progData(progData));

	// 200 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// own oscillator: 8 clocks a period, edges only on falling clock edges
	initial
	begin
		wdtOscPin = 1'b0;
		forever #20 wdtOscPin = ~wdtOscPin;
	end

	// tick counters and fetch trace
	always @(posedge clock)
	begin
		if (instrTick === 1'b1)
			tkCnt++;
		if (watchdogTick === 1'b1)
			wdCnt++;
		if (instrTick === 1'b1 && sys_rst === 1'b0 && progAddr !== 11'h000)
			trace.push_back(progAddr);
	end

	task automatic tick(input int n);
	begin
		repeat (n) @(posedge clock);
		#1;
	end
	endtask

	task automatic cmpVal(input string what, input logic [15:0] expV, input logic [15:0] gotV);
	begin
		checks++;
		if (gotV !== expV)
		begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", what, expV, gotV);
		end
	end
	endtask

	task automatic cmpCnt(input string what, input int expV, input int gotV);
	begin
		checks++;
		if (gotV != expV)
		begin
			errTotal++;
			$display("[ERR] %s expected %0d seen %0d", what, expV, gotV);
		end
	end
	endtask

	task automatic complete_run;
	begin
		$display("checks %0d errors %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask

	// expected {carry, result}; memory operand b, accumulator a
	function automatic logic [8:0] modelOp(input logic [3:0] op, input logic [2:0] s, input logic [7:0] a,
		input logic [7:0] b);
	begin
		if (op == citc_pkg::OP_ROT)
			case (s)
				citc_pkg::ROT_R:  return {1'b0, b[0], b[7:1]};
				citc_pkg::ROT_L:  return {1'b0, b[6:0], b[7]};
				citc_pkg::ROT_RC: return {b[0], 1'b0, b[7:1]};
				default:          return {b[7], b[6:0], 1'b0};
			endcase
		case (s)
			citc_pkg::ALU_ADD: return {1'b0, a} + {1'b0, b};
			citc_pkg::ALU_SUB: return {a < b, a - b};
			citc_pkg::ALU_AND: return {1'b0, a & b};
			citc_pkg::ALU_OR:  return {1'b0, a | b};
			citc_pkg::ALU_XOR: return {1'b0, a ^ b};
			citc_pkg::ALU_CPL: return {1'b0, ~b};
			citc_pkg::ALU_INC: return {1'b0, b + 8'h01};
			default:           return {1'b0, b - 8'h01};
		endcase
	end
	endfunction

	// debounce code 3 is not a legal choice, held as 2
	function automatic citc_pkg::citc_cfg_t optClamp(input citc_pkg::citc_cfg_t c);
	begin
		if (c.dbnc == 2'h3)
			c.dbnc = citc_pkg::DBNC_MAX;
		return c;
	end
	endfunction

	// options only taken while reset is high
	task automatic startRun(input citc_pkg::citc_cfg_t cfg);
	begin
		trace.delete();
		sys_rst = 1'b1;
		cfgIn = cfg;
		tick(3);
		sys_rst = 1'b0;
	end
	endtask

	// load b, store it, load a, operate, optionally reload, then park
	task automatic trial(input logic [3:0] op, input logic [2:0] s, input logic [7:0] a, input logic [7:0] b,
		input logic toMem);
		citc_pkg::citc_cfg_t cfg; // options under test
		logic [8:0]          res; // expected carry and result
	begin
		res = modelOp(op, s, a, b);
		cfg = citc_pkg::citc_cfg_t'(16'($random(seed)));
		wakePortPins = 8'($random(seed));
		pm.mem[0] = {citc_pkg::OP_MOVI, 3'h0, b};
		pm.mem[1] = {citc_pkg::OP_MOVA, 1'b1, 3'h0, 7'h10};
		pm.mem[2] = {citc_pkg::OP_MOVI, 3'h0, a};
		pm.mem[3] = {op, toMem, s, 7'h10};
		pm.mem[4] = toMem ? {citc_pkg::OP_LDA, 11'h010} : {citc_pkg::OP_NOP, 11'h000};
		pm.mem[5] = {citc_pkg::OP_JMP, 11'h005};
		startRun(cfg);
		cfgIn = ~cfg; // later changes must not reach the options
		tick(76);
		cmpVal("acc", 16'(res[7:0]), 16'(accOut));
		if (!toMem)
		begin
			cmpVal("carry", 16'(res[8]), 16'(carryFlag));
			if (op == citc_pkg::OP_ALU)
				cmpVal("zero", 16'(res[7:0] == 8'h00), 16'(zeroFlag));
		end
		cmpVal("options", 16'(optClamp(cfg)), 16'(cfgOut));
		cmpVal("wake", 16'(|(cfg.wakeEn & wakePortPins)), 16'(wakeReq));
		tkCnt = 0;
		wdCnt = 0;
		tick(64);
		cmpCnt("instr ticks", 16, tkCnt);
		cmpCnt("watchdog ticks", cfg.wdtEn ? (cfg.wdtOwnOsc ? 8 : 16) : 0, wdCnt);
	end
	endtask

	initial
	begin
		logic [3:0] op; // opcode of this trial
		logic [2:0] s;  // sub code of this trial
		sys_rst = 1'b1;
		cfgIn = '0;
		wakePortPins = 8'h00;
		errTotal = 0;
		checks = 0;
		for (int i = 0; i < 2048; i++)
			pm.mem[i] = 15'h0000;
		// every alu and rotate code: corner operands, then random, then random destination
		for (int n = 0; n < 36; n++)
		begin
			op = (n % 12 < 8) ? citc_pkg::OP_ALU : citc_pkg::OP_ROT;
			s = 3'(n % 12);
			if (n < 12)
				trial(op, s, n == 0 ? 8'hFF : 8'h00, 8'h01, 1'b0);
			else
				trial(op, s, 8'($random(seed)), 8'($random(seed)), n >= 24 && 1'($random(seed)));
		end
		// flow: taken skip, call and return, untaken bit skip, pc write, table read
		pm.mem[0] = {citc_pkg::OP_MOVI, 3'h0, 8'h00};
		pm.mem[2] = {citc_pkg::OP_SZ, 1'b0, 3'h0, 7'h10};
		pm.mem[3] = {citc_pkg::OP_MOVI, 3'h0, 8'h11};
		pm.mem[4] = {citc_pkg::OP_CALL, 11'h020};
		pm.mem[5] = {citc_pkg::OP_SBZ, 1'b0, 3'h0, 7'h12};
		pm.mem[6] = {citc_pkg::OP_MOVI, 3'h0, 8'h30};
		pm.mem[7] = {citc_pkg::OP_MOVA, 1'b1, 3'h0, citc_pkg::PCL_IDX};
		pm.mem[11'h020] = {citc_pkg::OP_MOVI, 3'h0, 8'h01};
		pm.mem[11'h021] = {citc_pkg::OP_MOVA, 1'b1, 3'h0, 7'h12};
		pm.mem[11'h022] = {citc_pkg::OP_RET, 11'h000};
		pm.mem[11'h030] = {citc_pkg::OP_MOVI, 3'h0, 8'h60};
		pm.mem[11'h031] = {citc_pkg::OP_TAB, 11'h000};
		pm.mem[11'h032] = {citc_pkg::OP_JMP, 11'h032};
		pm.mem[11'h060] = 15'h00A5;
		startRun(citc_pkg::citc_cfg_t'(16'($random(seed))));
		tick(160);
		for (int i = 0; i < 16; i++)
			cmpVal("fetch", 16'(expTr[i]), 16'(i < trace.size() ? trace[i] : 11'h7FF));
		cmpVal("table acc", 16'h00A5, 16'(accOut));
		complete_run();
	end

	// hang guard
	initial
	begin
		repeat (50000) @(posedge clock);
		errTotal++;
		complete_run();
	end
endmodule
